// ---- src/slip_session_control.sv ----
// framed serial line session and data path controller
`include "slip_session_cfg.svh"
module slip_session_control (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// commands from the command interpreter
	input wire logic svcWrite,
	input wire logic [7:0] svcValue,
	input wire logic autoAnsWrite,
	input wire logic [7:0] autoAnsValue,
	input wire logic dialCmd,
	input wire logic onlineCmd,
	input wire logic hangupNormalCmd,
	input wire logic hangupForceCmd,
	input wire logic regModeWrite,
	input wire logic regModeValue,
	input wire logic networkEntry,
	input wire logic registerDone,
	input wire logic [1:0] dtrOption,
	input wire logic dtr,
	// host serial bytes
	input wire logic hostRxValid,
	input wire logic [7:0] hostRxData,
	input wire logic hostTxReady,
	// network side
	input wire logic netTxReady,
	input wire logic netRxValid,
	input wire logic [7:0] netRxData,
	// status and results
	output logic [7:0] packetServiceSelect,
	output logic [7:0] autoAnswerSetting,
	output logic registrationModeSel,
	output logic registrationStateFlag,
	output logic autoRegSuspended,
	output logic [1:0] cmdResult,
	output logic dataState,
	output logic sessionOnline,
	output logic dcd,
	output logic cts,
	output logic netRxReady,
	// data out
	output logic hostTxValid,
	output logic [7:0] hostTxData,
	output logic netTxValid,
	output logic [7:0] netTxData,
	output logic netTxSegEnd
);
	//==========================================================
	// session state
	slip_session_pkg::sess_t state;
	logic framed;
	logic dtrLast;
	logic dtrDrop;
	logic escHit;
	assign framed = packetServiceSelect == `SVC_FRAMED;
	assign dtrDrop = dtrLast & ~dtr;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dtrLast <= 1'b1;
		end else begin
			dtrLast <= dtr;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			packetServiceSelect <= 8'h00;
		end else if (svcWrite) begin
			packetServiceSelect <= svcValue;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			autoAnswerSetting <= 8'h00;
		end else if (svcWrite && svcValue == `SVC_FRAMED) begin
			autoAnswerSetting <= 8'h00;
		end else if (autoAnsWrite && (!framed || autoAnsValue == 8'h00)) begin
			autoAnswerSetting <= autoAnsValue;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdResult <= slip_session_pkg::RES_NONE;
		end else if (autoAnsWrite && framed && autoAnsValue != 8'h00) begin
			cmdResult <= slip_session_pkg::RES_ERROR;
		end else if (dialCmd && framed) begin
			cmdResult <= slip_session_pkg::RES_ERROR;
		end else if (onlineCmd && framed) begin
			cmdResult <= slip_session_pkg::RES_CONNECT;
		end else if (svcWrite || autoAnsWrite || hangupNormalCmd ||
			hangupForceCmd || regModeWrite) begin
			cmdResult <= slip_session_pkg::RES_OK;
		end else begin
			cmdResult <= slip_session_pkg::RES_NONE;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			registrationModeSel <= 1'b0;
		end else if (regModeWrite) begin
			registrationModeSel <= regModeValue;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			autoRegSuspended <= 1'b0;
		end else if (hangupForceCmd) begin
			autoRegSuspended <= 1'b1;
		end else if ((regModeWrite && regModeValue) || networkEntry) begin
			autoRegSuspended <= 1'b0;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			registrationStateFlag <= 1'b0;
		end else if (hangupForceCmd) begin
			registrationStateFlag <= 1'b0;
		end else if (hangupNormalCmd && !registrationModeSel) begin
			registrationStateFlag <= 1'b0;
		end else if (state == slip_session_pkg::ST_DATA && dtrDrop &&
			dtrOption == 2'd2 && !registrationModeSel) begin
			registrationStateFlag <= 1'b0;
		end else if (regModeWrite && !regModeValue) begin
			registrationStateFlag <= 1'b0;
		end else if (registerDone) begin
			registrationStateFlag <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= slip_session_pkg::ST_CMD;
		end else begin
			case (state)
				slip_session_pkg::ST_CMD: begin
					if (onlineCmd && framed) begin
						state <= slip_session_pkg::ST_DATA;
					end
				end
				slip_session_pkg::ST_DATA: begin
					if (hangupNormalCmd || hangupForceCmd) begin
						state <= slip_session_pkg::ST_CMD;
					end else if (dtrDrop && dtrOption == 2'd2) begin
						state <= slip_session_pkg::ST_CMD;
					end else if (escHit || (dtrDrop && dtrOption == 2'd1)) begin
						state <= slip_session_pkg::ST_HELD;
					end
				end
				slip_session_pkg::ST_HELD: begin
					if (hangupNormalCmd || hangupForceCmd) begin
						state <= slip_session_pkg::ST_CMD;
					end else if (onlineCmd) begin
						state <= slip_session_pkg::ST_DATA;
					end
				end
				default: state <= slip_session_pkg::ST_CMD;
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dataState <= 1'b0;
			sessionOnline <= 1'b0;
			dcd <= 1'b0;
		end else begin
			dataState <= state == slip_session_pkg::ST_DATA;
			sessionOnline <= state != slip_session_pkg::ST_CMD;
			dcd <= state != slip_session_pkg::ST_CMD;
		end
	end
	//==========================================================
	// escape frame detection on host bytes
	logic [2:0] frameLen;
	logic allPlus;
	logic hostByte;
	assign hostByte = hostRxValid && cts &&
		state == slip_session_pkg::ST_DATA;
	assign escHit = hostByte && hostRxData == `FRAME_END &&
		frameLen == 3'd3 && allPlus;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			frameLen <= 3'd0;
			allPlus <= 1'b1;
		end else if (hostByte) begin
			if (hostRxData == `FRAME_END) begin
				frameLen <= 3'd0;
				allPlus <= 1'b1;
			end else begin
				frameLen <= frameLen == 3'd4 ? 3'd4 : frameLen + 3'd1;
				allPlus <= allPlus && hostRxData == `ESC_CHAR;
			end
		end
	end
	//==========================================================
	// transmit buffer host to network
	logic [7:0] txMem [0:`BUF_BYTES-1];
	logic [`BUF_AW-1:0] txWr;
	logic [`BUF_AW-1:0] txRd;
	logic [`BUF_AW:0] txCnt;
	logic [7:0] txSeg;
	logic txPush;
	logic txPop;
	logic [`BUF_AW-1:0] txWrFix;
	logic [`BUF_AW:0] txCntFix;
	logic [`BUF_AW:0] next_txCnt;
	logic [2:0] holdCnt;
	// bytes of a possible escape frame are held back until it resolves
	assign holdCnt = allPlus && frameLen != 3'd4 ? frameLen : 3'd0;
	assign txPush = hostByte && !escHit;
	assign txPop = (!netTxValid || netTxReady) && txCnt > {9'd0, holdCnt};
	always_ff @(posedge core_clk) begin
		if (txPush) begin
			txMem[txWr] <= hostRxData;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			txWr <= '0;
			txRd <= '0;
			txCnt <= '0;
			cts <= 1'b1;
		end else begin
			if (escHit) begin
				txWr <= txWrFix;
			end else if (txPush) begin
				txWr <= txWr == `BUF_BYTES - 11'd1 ? '0 : txWr + 11'd1;
			end
			if (txPop) begin
				txRd <= txRd == `BUF_BYTES - 11'd1 ? '0 : txRd + 11'd1;
			end
			txCnt <= next_txCnt;
			cts <= next_txCnt < {1'b0, `BUF_BYTES} - 12'd4;
		end
	end
	// withdraw the three held plus bytes
	assign txWrFix = txWr >= 11'd3 ? txWr - 11'd3 : txWr + `BUF_BYTES - 11'd3;
	assign txCntFix = txCnt - 12'd3;
	assign next_txCnt = (escHit ? txCntFix : txCnt) + {11'd0, txPush} -
		{11'd0, txPop};
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			netTxValid <= 1'b0;
			netTxData <= 8'h00;
			netTxSegEnd <= 1'b0;
			txSeg <= 8'h00;
		end else if (txPop) begin
			netTxValid <= 1'b1;
			netTxData <= txMem[txRd];
			netTxSegEnd <= txSeg == 8'h7F;
			txSeg <= txSeg == 8'h7F ? 8'h00 : txSeg + 8'h01;
		end else if (netTxReady) begin
			netTxValid <= 1'b0;
			netTxSegEnd <= 1'b0;
		end
	end
	//==========================================================
	// receive buffer network to host
	logic [7:0] rxMem [0:`BUF_BYTES-1];
	logic [`BUF_AW-1:0] rxWr;
	logic [`BUF_AW-1:0] rxRd;
	logic [`BUF_AW:0] rxCnt;
	logic rxPush;
	logic rxPop;
	assign rxPush = netRxValid && netRxReady;
	assign rxPop = state == slip_session_pkg::ST_DATA && rxCnt != 12'd0 &&
		(!hostTxValid || hostTxReady);
	always_ff @(posedge core_clk) begin
		if (rxPush) begin
			rxMem[rxWr] <= netRxData;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxWr <= '0;
			rxRd <= '0;
			rxCnt <= '0;
			netRxReady <= 1'b0;
		end else begin
			if (rxPush) begin
				rxWr <= rxWr == `BUF_BYTES - 11'd1 ? '0 : rxWr + 11'd1;
			end
			if (rxPop) begin
				rxRd <= rxRd == `BUF_BYTES - 11'd1 ? '0 : rxRd + 11'd1;
			end
			rxCnt <= rxCnt + {11'd0, rxPush} - {11'd0, rxPop};
			netRxReady <= state != slip_session_pkg::ST_CMD &&
				rxCnt < {1'b0, `BUF_BYTES} - 12'd2;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hostTxValid <= 1'b0;
			hostTxData <= 8'h00;
		end else if (rxPop) begin
			hostTxValid <= 1'b1;
			hostTxData <= rxMem[rxRd];
		end else if (hostTxReady) begin
			hostTxValid <= 1'b0;
		end
	end
	//==========================================================
	// checks
	property p_esc_held;
		@(posedge core_clk) disable iff (!rst_b)
		escHit && !hangupNormalCmd && !hangupForceCmd && !dtrDrop |=>
			state == slip_session_pkg::ST_HELD ##1 sessionOnline;
	endproperty
	a_esc_held: assert property (p_esc_held) else $error("escape lost");
	property p_ans_err;
		@(posedge core_clk) disable iff (!rst_b)
		autoAnsWrite && framed && autoAnsValue != 8'h00 && !svcWrite |=>
			cmdResult == slip_session_pkg::RES_ERROR &&
			$stable(autoAnswerSetting);
	endproperty
	a_ans_err: assert property (p_ans_err) else $error("ans accepted");
	property p_sel_clear;
		@(posedge core_clk) disable iff (!rst_b)
		svcWrite && svcValue == `SVC_FRAMED |=> autoAnswerSetting == 8'h00;
	endproperty
	a_sel_clear: assert property (p_sel_clear) else $error("ans kept");
	property p_dial_err;
		@(posedge core_clk) disable iff (!rst_b)
		dialCmd && framed && !autoAnsWrite |=>
			cmdResult == slip_session_pkg::RES_ERROR;
	endproperty
	a_dial_err: assert property (p_dial_err) else $error("dial ok");
	property p_online;
		@(posedge core_clk) disable iff (!rst_b)
		onlineCmd && framed && state == slip_session_pkg::ST_CMD |=>
			state == slip_session_pkg::ST_DATA ##1 dataState;
	endproperty
	a_online: assert property (p_online) else $error("no data state");
	property p_force;
		@(posedge core_clk) disable iff (!rst_b)
		hangupForceCmd |=> !registrationStateFlag && autoRegSuspended;
	endproperty
	a_force: assert property (p_force) else $error("still registered");
	property p_cts;
		@(posedge core_clk) disable iff (!rst_b)
		txCnt >= 12'h6FC |-> !cts;
	endproperty
	a_cts: assert property (p_cts) else $error("cts while full");
	property p_cap;
		@(posedge core_clk) disable iff (!rst_b)
		txCnt <= {1'b0, `BUF_BYTES} && rxCnt <= {1'b0, `BUF_BYTES};
	endproperty
	a_cap: assert property (p_cap) else $error("overflow");
	property p_esc_room;
		@(posedge core_clk) disable iff (!rst_b)
		escHit |-> txCnt >= 12'd3;
	endproperty
	a_esc_room: assert property (p_esc_room) else $error("plus gone");
	property p_hold;
		@(posedge core_clk) disable iff (!rst_b)
		state != slip_session_pkg::ST_DATA && !hostTxValid |=>
			!hostTxValid;
	endproperty
	a_hold: assert property (p_hold) else $error("rx leaked");
	property p_dtr2;
		@(posedge core_clk) disable iff (!rst_b)
		state == slip_session_pkg::ST_DATA && dtrDrop && dtrOption == 2'd2 &&
			!hangupNormalCmd && !hangupForceCmd |=>
			state == slip_session_pkg::ST_CMD ##1 !dcd;
	endproperty
	a_dtr2: assert property (p_dtr2) else $error("dtr2 ignored");
endmodule // slip_session_control

// ---- src/slip_session_cfg.svh ----
// constants for the framed serial line session controller
//==========================================================
// Function
// - writing packet service select with 3 selects framed serial service
// - framed mode relays bytes unchanged; 0xC0 delimits frames
// - selecting framed service forces auto-answer setting to zero
// - nonzero auto-answer write in framed service answers ERROR
// - dial command unsupported in framed service; only online enters data
// - online command answers CONNECT regardless of registration
// - every network byte goes to host whatever its source
// - host data sent in 128-byte segments, 14 segments buffered
// - full transmit buffer drops CTS; host stops until CTS returns
// - network data buffered up to 14 segments, delivered as it arrives
// - command state while on-line holds network data, remote flow control
// - frame holding only +++ is escape, never forwarded
// - escape enters command state, session open, still registered
// - DTR option 1 drop acts as escape
// - DTR option 2 drop in data state closes session, de-registers, command state
// - DTR option 2 with auto registration keeps registration
// - online with open session answers CONNECT and resumes data
// - hang-ups close session; manual registration also de-registers
// - forced hang-up de-registers; auto resumes only on mode rewrite or reentry
`ifndef SLIP_SESSION_CFG_SVH
`define SLIP_SESSION_CFG_SVH
`define SVC_FRAMED 8'h03
`define FRAME_END 8'hC0
`define ESC_CHAR 8'h2B
`define SEG_BYTES 11'h080
`define SEG_COUNT 5'h0E
`define BUF_BYTES 11'h700
`define BUF_AW 11
`endif

// ---- src/slip_session_pkg.sv ----
// types for the framed serial line session controller
package slip_session_pkg;
	typedef enum logic [2:0] {
		ST_CMD = 3'b001,
		ST_DATA = 3'b010,
		ST_HELD = 3'b100
	} sess_t;
	typedef enum logic [1:0] {
		RES_NONE = 2'h0,
		RES_OK = 2'h1,
		RES_CONNECT = 2'h2,
		RES_ERROR = 2'h3
	} result_t;
endpackage

// ---- bench/host_model.sv ----
// host terminal model for the session controller bench
module host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// bench control
	input wire logic slow,
	// device side
	input wire logic cts,
	input wire logic hostTxValid,
	input wire logic [7:0] hostTxData,
	output logic hostRxValid,
	output logic [7:0] hostRxData,
	output logic hostTxReady
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	int sent;
	// ====================
	// send, each byte held until cts
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hostRxValid <= 1'b0;
			hostRxData <= 8'h5A;
			sent <= 0;
		end else if (!hostRxValid || cts) begin
			sent <= sent + int'(hostRxValid);
			hostRxValid <= txq.size() > 0;
			hostRxData <= txq.size() > 0 ? txq.pop_front() : ~hostRxData;
		end
	end
	// ====================
	// receive, stalls every other cycle when slow
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hostTxReady <= 1'b0;
		end else begin
			hostTxReady <= slow ? !hostTxReady : 1'b1;
			if (hostTxValid && hostTxReady)
				rxq.push_back(hostTxData);
		end
	end
endmodule // host_model

// ---- bench/slip_session_control_test.sv ----
// self-checking bench for the session controller
module slip_session_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [8:0] SVC = 9'h100, AA = 9'h080, DIAL = 9'h040;
	localparam logic [8:0] ON = 9'h020, HN = 9'h010, HF = 9'h008;
	localparam logic [8:0] RM = 9'h004, NE = 9'h002, RD = 9'h001;
	logic core_clk, rst_b, slow, dtr, netTxReady, netRxValid;
	logic [8:0] cmds;
	logic [7:0] cmdVal, netRxData, hostRxData, hostTxData, netTxData;
	logic [7:0] svcSel, autoAns;
	logic [1:0] dtrOption, cmdResult, r;
	logic hostRxValid, hostTxReady, hostTxValid, cts, netRxReady;
	logic netTxValid, netTxSegEnd, regMode, regFlag, regSusp;
	logic dataState, sessionOnline, dcd;
	logic [7:0] netq[$];
	logic segq[$];
	int err_count, n_checks, cnt, bad;
	slip_session_control DUT (.core_clk(core_clk), .rst_b(rst_b),
		.svcWrite(cmds[8]), .svcValue(cmdVal), .autoAnsWrite(cmds[7]),
		.autoAnsValue(cmdVal), .dialCmd(cmds[6]), .onlineCmd(cmds[5]),
		.hangupNormalCmd(cmds[4]), .hangupForceCmd(cmds[3]),
		.regModeWrite(cmds[2]), .regModeValue(cmdVal[0]),
		.networkEntry(cmds[1]), .registerDone(cmds[0]),
		.dtrOption(dtrOption), .dtr(dtr), .hostRxValid(hostRxValid),
		.hostRxData(hostRxData), .hostTxReady(hostTxReady),
		.netTxReady(netTxReady), .netRxValid(netRxValid),
		.netRxData(netRxData), .packetServiceSelect(svcSel),
		.autoAnswerSetting(autoAns), .registrationModeSel(regMode),
		.registrationStateFlag(regFlag), .autoRegSuspended(regSusp),
		.cmdResult(cmdResult), .dataState(dataState),
		.sessionOnline(sessionOnline), .dcd(dcd), .cts(cts),
		.netRxReady(netRxReady), .hostTxValid(hostTxValid),
		.hostTxData(hostTxData), .netTxValid(netTxValid),
		.netTxData(netTxData), .netTxSegEnd(netTxSegEnd));
	host_model host (.core_clk(core_clk), .rst_b(rst_b), .slow(slow),
		.cts(cts), .hostTxValid(hostTxValid), .hostTxData(hostTxData),
		.hostRxValid(hostRxValid), .hostRxData(hostRxData),
		.hostTxReady(hostTxReady));
	// ====================
	// helpers
	always @(posedge core_clk) begin
		if (netTxValid === 1'b1 && netTxReady) begin
			netq.push_back(netTxData);
			segq.push_back(netTxSegEnd);
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic ck(input logic c, input string m);
		n_checks++;
		if (c !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic tmo(input int n, input string m);
		if (n > 8000) begin
			ck(1'b0, m);
			end_of_test();
		end
		repeat (1) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(input logic [8:0] m, input logic [7:0] v);
		@(posedge core_clk);
		cmds <= m;
		cmdVal <= v;
		@(posedge core_clk);
		cmds <= 9'h000;
		r = 2'h0;
		repeat (3) begin
			#1;
			if (cmdResult !== 2'h0)
				r = cmdResult;
			@(posedge core_clk);
		end
		#1;
	endtask
	// ====================
	// scenarios
	task automatic t_select();
		pulse(SVC, 8'h00);
		pulse(AA, 8'h05);
		ck(autoAns === 8'h05, "aa set");
		pulse(SVC, 8'h03);
		ck(svcSel === 8'h03, "svc");
		ck(autoAns === 8'h00, "aa cleared");
		pulse(AA, 8'h05);
		ck(r === slip_session_pkg::RES_ERROR, "aa err");
		ck(autoAns === 8'h00, "aa kept");
		pulse(AA, 8'h00);
		ck(r === slip_session_pkg::RES_OK, "aa zero");
		pulse(DIAL, 8'h00);
		ck(r === slip_session_pkg::RES_ERROR, "dial");
		ck(dataState === 1'b0, "no data");
		$display("test select done");
	endtask
	task automatic t_online();
		pulse(RM, 8'h00);
		pulse(ON, 8'h00);
		ck(r === slip_session_pkg::RES_CONNECT, "online");
		ck(dataState === 1'b1 && regFlag === 1'b0, "data");
		pulse(RD, 8'h00);
		for (cnt = 0; regFlag !== 1'b1; cnt++)
			tmo(cnt * 400, "reg poll");
		$display("test online done");
	endtask
	task automatic t_tx();
		@(posedge core_clk);
		netTxReady <= 1'b0;
		for (int i = 0; i < 1800; i++)
			host.txq.push_back(8'h30 + 8'(i % 64));
		repeat (2000) @(posedge core_clk);
		#1;
		ck(cts === 1'b0, "cts low");
		ck(host.sent >= 1788 && host.sent <= 1793, "depth");
		ck(netq.size() == 0, "held");
		@(posedge core_clk);
		netTxReady <= 1'b1;
		for (cnt = 0; netq.size() < 1800; cnt++)
			tmo(cnt, "tx drain");
		bad = 0;
		foreach (netq[i])
			if (netq[i] !== 8'h30 + 8'(i % 64) || segq[i] !== (i % 128 == 127))
				bad++;
		ck(bad == 0, "tx data");
		$display("test tx done");
	endtask
	task automatic t_escape();
		logic [7:0] esc[5] = '{8'hC0, 8'h2B, 8'h2B, 8'h2B, 8'hC0};
		@(posedge core_clk);
		netq.delete();
		segq.delete();
		foreach (esc[i])
			host.txq.push_back(esc[i]);
		repeat (30) @(posedge core_clk);
		#1;
		ck(dataState === 1'b0, "escape");
		ck(sessionOnline === 1'b1 && regFlag === 1'b1, "kept");
		repeat (30) @(posedge core_clk);
		bad = 0;
		foreach (netq[i])
			bad += int'(netq[i] === 8'h2B);
		ck(bad == 0, "escape sent");
		$display("test escape done");
	endtask
	task automatic t_held();
		@(posedge core_clk);
		slow <= 1'b1;
		for (cnt = 0; cnt < 1800; cnt++) begin
			netRxValid <= 1'b1;
			netRxData <= 8'(cnt);
			for (bad = 0; bad < 50; bad++) begin
				@(posedge core_clk);
				if (netRxReady === 1'b1)
					break;
			end
			if (bad == 50)
				break;
		end
		netRxValid <= 1'b0;
		netRxData <= ~netRxData;
		#1;
		ck(cnt >= 1790 && cnt <= 1793, "rx depth");
		ck(host.rxq.size() == 0, "rx held");
		pulse(ON, 8'h00);
		ck(r === slip_session_pkg::RES_CONNECT, "resume");
		ck(dataState === 1'b1, "resumed");
		for (bad = 0; host.rxq.size() < cnt; bad++)
			tmo(bad, "rx drain");
		bad = 0;
		for (int i = 0; i < cnt; i++)
			bad += int'(host.rxq[i] !== 8'(i));
		ck(bad == 0, "rx data");
		$display("test held done");
	endtask
	task automatic t_dtr();
		@(posedge core_clk);
		dtrOption <= 2'h1;
		dtr <= 1'b0;
		repeat (5) @(posedge core_clk);
		dtr <= 1'b1;
		#1;
		ck(dataState === 1'b0 && sessionOnline === 1'b1, "d1");
		ck(regFlag === 1'b1, "d1 reg");
		@(posedge core_clk);
		dtrOption <= 2'h2;
		pulse(ON, 8'h00);
		@(posedge core_clk);
		dtr <= 1'b0;
		repeat (5) @(posedge core_clk);
		dtr <= 1'b1;
		#1;
		ck(sessionOnline === 1'b0 && dcd === 1'b0, "d2");
		ck(regFlag === 1'b0 && dataState === 1'b0, "d2 reg");
		pulse(RM, 8'h01);
		pulse(RD, 8'h00);
		pulse(ON, 8'h00);
		@(posedge core_clk);
		dtr <= 1'b0;
		repeat (5) @(posedge core_clk);
		dtr <= 1'b1;
		#1;
		ck(dcd === 1'b0 && regFlag === 1'b1, "d2 auto");
		$display("test dtr done");
	endtask
	task automatic t_hangup();
		pulse(ON, 8'h00);
		pulse(HN, 8'h00);
		ck(sessionOnline === 1'b0 && regFlag === 1'b1, "h auto");
		pulse(ON, 8'h00);
		pulse(HF, 8'h00);
		ck(regFlag === 1'b0 && regSusp === 1'b1, "hf");
		pulse(RM, 8'h01);
		ck(regSusp === 1'b0 && regMode === 1'b1, "rewrite");
		pulse(HF, 8'h00);
		pulse(NE, 8'h00);
		ck(regSusp === 1'b0, "reentry");
		pulse(RM, 8'h00);
		pulse(RD, 8'h00);
		pulse(ON, 8'h00);
		pulse(HN, 8'h00);
		ck(sessionOnline === 1'b0 && regFlag === 1'b0, "h man");
		$display("test hangup done");
	endtask
	// ====================
	// clock and main sequence
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		{rst_b, slow, netRxValid, cmds, cmdVal, netRxData} = '0;
		{dtr, netTxReady, dtrOption, err_count, n_checks} = '0;
		dtr = 1'b1;
		netTxReady = 1'b1;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		t_select();
		t_online();
		t_tx();
		t_escape();
		t_held();
		t_dtr();
		t_hangup();
		end_of_test();
	end
endmodule // slip_session_control_test
